// ===== rtl/ioch_equipment.sv
// External equipment end of a 12-bit bidirectional data channel.
// Assumes all channel pins are asynchronous and held steady for a full handshake.
// Contract
// - Twelve shared data lines; equipment drives on read, channel drives on write.
// - Each twelve-bit word travels with one bit making the ones count odd.
// - Equipment holds reply for a strobe and releases it when the strobe falls.
// - On connect, equipment able to connect becomes connected and replies.
// - On function, equipment able to perform it starts it and replies.
// - On input, equipment replies right after placing a word on the lines.
// - On output, equipment replies right after sampling the data lines.
// - Equipment answers connect or function with steady reject when unable.
// - On input, equipment answers data strobe with end of record at block end.
// - Parity error rises when data plus parity bit hold an even ones count.
// - Equipment reports its condition on twelve status lines.
// - Up to eight equipments, each owning one interrupt line driven on condition.
`timescale 1ns/100ps
`default_nettype none
module ioch_equipment #(
    parameter logic [ioch_pkg::DATA_W-1:0] CONNECT_CODE = ioch_pkg::CONNECT_CODE_DFLT,
    parameter int UNIT_INDEX = 0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ioch_pkg::DATA_W-1:0] chDataIn,
    input wire logic chParityIn,
    input wire logic chRead,
    input wire logic chWrite,
    input wire logic chConnect,
    input wire logic chFunction,
    input wire logic chDataStrobe,
    input wire logic chMasterClear,
    input wire logic chRunning,
    output logic [ioch_pkg::DATA_W-1:0] chDataOut,
    output logic chParityOut,
    output logic chDataOe,
    output logic chReply,
    output logic chReject,
    output logic chEndOfRecord,
    output logic chParityError,
    output logic [ioch_pkg::STATUS_W-1:0] chStatus,
    output logic [ioch_pkg::MAX_EQUIP-1:0] chInterrupt,
    input wire logic usrConnectOk,
    input wire logic usrFunctionOk,
    input wire logic [ioch_pkg::STATUS_W-1:0] usrStatus,
    input wire logic usrIntCond,
    input wire logic usrTxValid,
    input wire logic [ioch_pkg::DATA_W-1:0] usrTxData,
    input wire logic usrTxEnd,
    output logic usrTxTaken,
    output logic usrRxValid,
    output logic [ioch_pkg::DATA_W-1:0] usrRxData,
    output logic usrFuncValid,
    output logic [ioch_pkg::DATA_W-1:0] usrFuncCode,
    output logic usrConnected,
    output logic usrMasterClear
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [ioch_pkg::SYNC_W-1:0] syncA_q;
    logic [ioch_pkg::SYNC_W-1:0] syncA_d;
    logic [ioch_pkg::SYNC_W-1:0] syncB_q;
    logic [ioch_pkg::SYNC_W-1:0] syncB_d;

    always_comb begin
        syncA_d = {chDataIn, chParityIn, chRead, chWrite, chConnect, chFunction,
                   chDataStrobe, chMasterClear, chRunning};
        syncB_d = syncA_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA_q <= ioch_pkg::SYNC_RST;
            syncB_q <= ioch_pkg::SYNC_RST;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
        end
    end

    logic [ioch_pkg::DATA_W-1:0] sData;
    logic sParity;
    logic sRead;
    logic sWrite;
    logic sConnect;
    logic sFunction;
    logic sStrobe;
    logic sMasterClear;
    logic sRunning;

    assign {sData, sParity, sRead, sWrite, sConnect, sFunction, sStrobe, sMasterClear, sRunning} = syncB_q;

    // ****************************************
    // Parity
    // ****************************************
    logic rxParityOk;
    logic txParityBit;

    ioch_parity #(.WIDTH(ioch_pkg::DATA_W)) rxParity (
        .word(sData),
        .parityIn(sParity),
        .parityGen(),
        .parityOk(rxParityOk)
    );

    ioch_parity #(.WIDTH(ioch_pkg::DATA_W)) txParity (
        .word(usrTxData),
        .parityIn(1'b0),
        .parityGen(txParityBit),
        .parityOk()
    );

    // ****************************************
    // Handshake state
    // ****************************************
    ioch_pkg::ioch_state_e state_q;
    ioch_pkg::ioch_state_e state_d;
    logic connected_q, connected_d;
    logic reply_q, reply_d;
    logic reject_q, reject_d;
    logic eor_q, eor_d;
    logic oe_q, oe_d;
    logic [ioch_pkg::DATA_W-1:0] dataOut_q, dataOut_d;
    logic parityOut_q, parityOut_d;
    logic parErr_q, parErr_d;
    logic txTaken_q, txTaken_d;
    logic rxValid_q, rxValid_d;
    logic [ioch_pkg::DATA_W-1:0] rxData_q, rxData_d;
    logic funcValid_q, funcValid_d;
    logic [ioch_pkg::DATA_W-1:0] funcCode_q, funcCode_d;
    logic anyStrobe;

    assign anyStrobe = sConnect | sFunction | sStrobe;

    always_comb begin
        state_d = state_q;
        connected_d = connected_q;
        reply_d = reply_q;
        reject_d = reject_q;
        eor_d = eor_q;
        oe_d = oe_q;
        dataOut_d = dataOut_q;
        parityOut_d = parityOut_q;
        parErr_d = parErr_q;
        rxData_d = rxData_q;
        funcCode_d = funcCode_q;
        txTaken_d = 1'b0;
        rxValid_d = 1'b0;
        funcValid_d = 1'b0;
        if (sMasterClear) begin
            // Back to zero state, disconnected, lines released
            state_d = ioch_pkg::ST_IDLE;
            connected_d = 1'b0;
            reply_d = 1'b0;
            reject_d = 1'b0;
            eor_d = 1'b0;
            oe_d = 1'b0;
            dataOut_d = ioch_pkg::DATA_RST;
            parityOut_d = 1'b0;
            parErr_d = 1'b0;
            rxData_d = ioch_pkg::DATA_RST;
            funcCode_d = ioch_pkg::DATA_RST;
        end else begin
            unique case (state_q)
                ioch_pkg::ST_IDLE: begin
                    if (sConnect) begin
                        parErr_d = ~rxParityOk;
                        state_d = ioch_pkg::ST_HOLD;
                        if (sData != CONNECT_CODE) begin
                            // Another unit addressed; stay silent
                            connected_d = 1'b0;
                        end else if (usrConnectOk && rxParityOk) begin
                            connected_d = 1'b1;
                            reply_d = 1'b1;
                        end else begin
                            reject_d = 1'b1;
                        end
                    end else if (sFunction && connected_q) begin
                        parErr_d = ~rxParityOk;
                        state_d = ioch_pkg::ST_HOLD;
                        if (usrFunctionOk && rxParityOk) begin
                            funcCode_d = sData;
                            funcValid_d = 1'b1;
                            reply_d = 1'b1;
                        end else begin
                            reject_d = 1'b1;
                        end
                    end else if (sStrobe && connected_q && sRead) begin
                        if (usrTxEnd) begin
                            eor_d = 1'b1;
                            state_d = ioch_pkg::ST_HOLD;
                        end else if (usrTxValid) begin
                            dataOut_d = usrTxData;
                            parityOut_d = txParityBit;
                            oe_d = 1'b1;
                            txTaken_d = 1'b1;
                            state_d = ioch_pkg::ST_DRIVE;
                        end
                    end else if (sStrobe && connected_q && sWrite) begin
                        rxData_d = sData;
                        rxValid_d = 1'b1;
                        parErr_d = ~rxParityOk;
                        reply_d = 1'b1;
                        state_d = ioch_pkg::ST_HOLD;
                    end
                end
                ioch_pkg::ST_DRIVE: begin
                    // Word stood on the lines for one cycle before reply
                    reply_d = 1'b1;
                    state_d = ioch_pkg::ST_HOLD;
                end
                ioch_pkg::ST_HOLD: begin
                    if (!anyStrobe) begin
                        reply_d = 1'b0;
                        reject_d = 1'b0;
                        eor_d = 1'b0;
                        oe_d = 1'b0;
                        state_d = ioch_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ioch_pkg::ST_IDLE;
            connected_q <= 1'b0;
            reply_q <= 1'b0;
            reject_q <= 1'b0;
            eor_q <= 1'b0;
            oe_q <= 1'b0;
            dataOut_q <= ioch_pkg::DATA_RST;
            parityOut_q <= 1'b0;
            parErr_q <= 1'b0;
            txTaken_q <= 1'b0;
            rxValid_q <= 1'b0;
            rxData_q <= ioch_pkg::DATA_RST;
            funcValid_q <= 1'b0;
            funcCode_q <= ioch_pkg::DATA_RST;
        end else begin
            state_q <= state_d;
            connected_q <= connected_d;
            reply_q <= reply_d;
            reject_q <= reject_d;
            eor_q <= eor_d;
            oe_q <= oe_d;
            dataOut_q <= dataOut_d;
            parityOut_q <= parityOut_d;
            parErr_q <= parErr_d;
            txTaken_q <= txTaken_d;
            rxValid_q <= rxValid_d;
            rxData_q <= rxData_d;
            funcValid_q <= funcValid_d;
            funcCode_q <= funcCode_d;
        end
    end

    // ****************************************
    // Status, interrupt and clear indication
    // ****************************************
    logic [ioch_pkg::STATUS_W-1:0] status_q, status_d;
    logic [ioch_pkg::MAX_EQUIP-1:0] int_q, int_d;
    logic mclr_q, mclr_d;

    always_comb begin
        status_d = sMasterClear ? ioch_pkg::STATUS_RST : usrStatus;
        mclr_d = sMasterClear;
    end

    // Only the line owned by this unit is ever raised
    for (genvar i = 0; i < ioch_pkg::MAX_EQUIP; i++) begin : gIntLine
        always_comb begin
            int_d[i] = (i == UNIT_INDEX) && usrIntCond && sRunning && !sMasterClear;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= ioch_pkg::STATUS_RST;
            int_q <= ioch_pkg::INT_RST;
            mclr_q <= 1'b0;
        end else begin
            status_q <= status_d;
            int_q <= int_d;
            mclr_q <= mclr_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign chDataOut = dataOut_q;
    assign chParityOut = parityOut_q;
    assign chDataOe = oe_q;
    assign chReply = reply_q;
    assign chReject = reject_q;
    assign chEndOfRecord = eor_q;
    assign chParityError = parErr_q;
    assign chStatus = status_q;
    assign chInterrupt = int_q;
    assign usrTxTaken = txTaken_q;
    assign usrRxValid = rxValid_q;
    assign usrRxData = rxData_q;
    assign usrFuncValid = funcValid_q;
    assign usrFuncCode = funcCode_q;
    assign usrConnected = connected_q;
    assign usrMasterClear = mclr_q;

endmodule : ioch_equipment
`default_nettype wire

// ===== rtl/ioch_pkg.sv
// Constants shared by the equipment-side channel controller.
// Assumes a single 25 MHz clock domain; the channel pins are asynchronous to it.
package ioch_pkg;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int DATA_W = 12;
    localparam int STATUS_W = 12;
    localparam int MAX_EQUIP = 8;
    localparam int SYNC_W = DATA_W + 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
    localparam logic [STATUS_W-1:0] STATUS_RST = 12'h000;
    localparam logic [MAX_EQUIP-1:0] INT_RST = 8'h00;
    localparam logic [SYNC_W-1:0] SYNC_RST = 20'h00000;

    // ****************************************
    // Defaults for the unit identity
    // ****************************************
    // Arbitrary value
    localparam logic [DATA_W-1:0] CONNECT_CODE_DFLT = 12'h001;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DRIVE,
        ST_HOLD
    } ioch_state_e;

endpackage : ioch_pkg

// ===== rtl/ioch_parity.sv
// Odd parity generator and checker for one channel word.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
`default_nettype none
module ioch_parity #(
    parameter int WIDTH = ioch_pkg::DATA_W
) (
    input wire logic [WIDTH-1:0] word,
    input wire logic parityIn,
    output logic parityGen,
    output logic parityOk
);

    // Bit that makes the count of ones in word plus bit odd
    assign parityGen = ~^word;
    // Even count of ones over word and bit is an error
    assign parityOk = ^{word, parityIn};

endmodule : ioch_parity
`default_nettype wire

// ===== testbench/ioch_equipment_monitor.sv
// Concurrent checks on the equipment end of the channel.
// Bound into ioch_equipment; watches its ports only.
`timescale 1ns/100ps
`default_nettype none
module ioch_equipment_monitor #(
    parameter logic [ioch_pkg::DATA_W-1:0] CONNECT_CODE = ioch_pkg::CONNECT_CODE_DFLT,
    parameter int UNIT_INDEX = 0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ioch_pkg::DATA_W-1:0] chDataIn,
    input wire logic chParityIn,
    input wire logic chRead,
    input wire logic chWrite,
    input wire logic chConnect,
    input wire logic chFunction,
    input wire logic chDataStrobe,
    input wire logic [ioch_pkg::DATA_W-1:0] chDataOut,
    input wire logic chParityOut,
    input wire logic chDataOe,
    input wire logic chReply,
    input wire logic chReject,
    input wire logic chEndOfRecord,
    input wire logic chParityError,
    input wire logic [ioch_pkg::MAX_EQUIP-1:0] chInterrupt,
    input wire logic usrConnectOk,
    input wire logic usrFunctionOk,
    input wire logic usrTxEnd,
    input wire logic usrTxTaken,
    input wire logic usrRxValid,
    input wire logic [ioch_pkg::DATA_W-1:0] usrRxData,
    input wire logic usrFuncValid,
    input wire logic usrConnected
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire goodPar = ^{chDataIn, chParityIn};
    property p_release;
        (!(chConnect || chFunction || chDataStrobe))[*4] |-> !(chReply || chReject || chEndOfRecord);
    endproperty
    property p_connect;
        $rose(chConnect) && chDataIn == CONNECT_CODE && goodPar && usrConnectOk |-> ##3 chReply && usrConnected;
    endproperty
    property p_refuse;
        $rose(chConnect) && chDataIn == CONNECT_CODE && !usrConnectOk |-> ##3 chReject && !chReply;
    endproperty
    property p_func;
        $rose(chFunction) && usrConnected && usrFunctionOk && goodPar |-> ##3 chReply && usrFuncValid;
    endproperty
    property p_write;
        $rose(chDataStrobe) && chWrite |-> ##3 chReply && usrRxValid && usrRxData == chDataIn;
    endproperty
    property p_read;
        $rose(chReply) && chRead |-> $past(chDataOe) && chDataOe;
    endproperty
    property p_taken;
        $rose(chDataOe) |-> usrTxTaken && chRead;
    endproperty
    property p_oddOut;
        chDataOe |-> ^{chDataOut, chParityOut};
    endproperty
    property p_eor;
        $rose(chDataStrobe) && chRead && usrTxEnd |-> ##3 chEndOfRecord && !chDataOe;
    endproperty
    property p_parErr;
        usrRxValid |-> chParityError == !goodPar;
    endproperty
    property p_intLine;
        (chInterrupt & ~(8'h01 << UNIT_INDEX)) == 8'h00;
    endproperty
    a_release: assert property (p_release) else $error("answer outlives the strobe");
    a_connect: assert property (p_connect) else $error("connect not answered by reply");
    a_refuse: assert property (p_refuse) else $error("refused connect not rejected");
    a_func: assert property (p_func) else $error("function not answered by reply");
    a_write: assert property (p_write) else $error("written word not sampled");
    a_read: assert property (p_read) else $error("read reply without word on lines");
    a_taken: assert property (p_taken) else $error("word driven without taken pulse");
    a_oddOut: assert property (p_oddOut) else $error("driven word has even parity");
    a_eor: assert property (p_eor) else $error("end of record missing");
    a_parErr: assert property (p_parErr) else $error("parity error flag wrong");
    a_intLine: assert property (p_intLine) else $error("foreign interrupt line driven");
    c_connect: cover property ($rose(chReply) && usrConnected);
    c_reject: cover property ($rose(chReject));
    c_eor: cover property ($rose(chEndOfRecord));
    c_read: cover property ($rose(chDataOe));
endmodule : ioch_equipment_monitor
bind ioch_equipment ioch_equipment_monitor #(.CONNECT_CODE(CONNECT_CODE), .UNIT_INDEX(UNIT_INDEX))
    ioch_equipment_monitor_inst (.clk, .rstn, .chDataIn, .chParityIn, .chRead, .chWrite, .chConnect, .chFunction,
    .chDataStrobe, .chDataOut, .chParityOut, .chDataOe, .chReply, .chReject, .chEndOfRecord, .chParityError,
    .chInterrupt, .usrConnectOk, .usrFunctionOk, .usrTxEnd, .usrTxTaken, .usrRxValid, .usrRxData, .usrFuncValid,
    .usrConnected);
`default_nettype wire

// ===== testbench/ioch_chan_model.sv
// Behavioural model of the computer's data channel driving the equipment pins.
// Tasks are called by the bench; they start and end just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module ioch_chan_model (
    input wire logic clk,
    input wire logic [11:0] chDataOut,
    input wire logic chParityOut,
    input wire logic chDataOe,
    input wire logic chReply,
    input wire logic chReject,
    input wire logic chEndOfRecord,
    output logic [11:0] chDataIn,
    output logic chParityIn,
    output var logic chRead,
    output var logic chWrite,
    output var logic chConnect,
    output var logic chFunction,
    output var logic chDataStrobe,
    output var logic chMasterClear,
    output var logic chRunning
);
    // ****************************************
    // Channel model
    // ****************************************
    logic [11:0] drvData;
    logic [11:0] seenWord;
    logic [12:0] lastWire;
    logic drvOe;
    logic badPar;
    logic seenPar;
    initial begin
        {drvData, drvOe, badPar, lastWire} = '0;
        {chRead, chWrite, chConnect, chFunction, chDataStrobe, chMasterClear} = 6'h00;
        chRunning = 1'b1;
    end
    // Released lines show the inverse of their last level
    assign chDataIn = chDataOe ? chDataOut : (drvOe ? drvData : ~lastWire[11:0]);
    assign chParityIn = chDataOe ? chParityOut : (drvOe ? ~(^drvData) ^ badPar : ~lastWire[12]);
    // Only a driven level is remembered, so a released bus holds one inverse value
    always @(posedge clk) begin
        if (chDataOe || drvOe) begin
            lastWire <= {chParityIn, chDataIn};
        end
    end
    // Kind 0 connect, 1 function, 2 write, 3 read; answer is {timeout, end, reject, reply}
    task automatic xfer(input int kind, input logic [11:0] w, input logic bad, output logic [3:0] ans);
        int n;
        drvData = w;
        badPar = bad;
        drvOe = kind != 3;
        chRead = kind == 3;
        chWrite = kind == 2;
        @(posedge clk);
        #1;
        chConnect = kind == 0;
        chFunction = kind == 1;
        chDataStrobe = kind > 1;
        n = 0;
        while (!(chReply || chReject || chEndOfRecord) && n < 20) begin
            @(posedge clk);
            n++;
        end
        ans = {n == 20, chEndOfRecord, chReject, chReply};
        seenWord = chDataIn;
        seenPar = chParityIn;
        #1;
        {chConnect, chFunction, chDataStrobe, drvOe} = 4'h0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((chReply || chReject || chEndOfRecord) && n < 20);
        // An answer that never falls counts as a timeout
        if (chReply || chReject || chEndOfRecord) begin
            ans[3] = 1'b1;
        end
        #1;
    endtask : xfer
    task automatic setLevels(input logic mc, input logic run);
        chMasterClear = mc;
        chRunning = run;
    endtask : setLevels
endmodule : ioch_chan_model
`default_nettype wire

// ===== testbench/io_channel_handshake_bench.sv
// Self-checking bench for the equipment end of the channel.
// User side driven here, channel side through ioch_chan_model.
`timescale 1ns/100ps
`default_nettype none
module io_channel_handshake_bench;
    localparam logic [11:0] CODE = 12'h2C7;
    localparam int UNIT = 3;
    logic clk, rstn, chParityIn, chRead, chWrite, chConnect, chFunction, chDataStrobe, chMasterClear, chRunning;
    logic chParityOut, chDataOe, chReply, chReject, chEndOfRecord, chParityError, usrConnectOk, usrFunctionOk;
    logic usrIntCond, usrTxValid, usrTxEnd, usrTxTaken, usrRxValid, usrFuncValid, usrConnected, usrMasterClear;
    logic [11:0] chDataIn, chDataOut, chStatus, usrStatus, usrTxData, usrRxData, usrFuncCode;
    logic [7:0] chInterrupt;
    int n_mismatch, checks_done;
    ioch_equipment #(.CONNECT_CODE(CODE), .UNIT_INDEX(UNIT)) ioch_equipment_inst (.clk, .rstn, .chDataIn,
        .chParityIn, .chRead, .chWrite, .chConnect, .chFunction, .chDataStrobe, .chMasterClear, .chRunning,
        .chDataOut, .chParityOut, .chDataOe, .chReply, .chReject, .chEndOfRecord, .chParityError, .chStatus,
        .chInterrupt, .usrConnectOk, .usrFunctionOk, .usrStatus, .usrIntCond, .usrTxValid, .usrTxData, .usrTxEnd,
        .usrTxTaken, .usrRxValid, .usrRxData, .usrFuncValid, .usrFuncCode, .usrConnected, .usrMasterClear);
    ioch_chan_model ioch_chan_model_inst (.clk, .chDataOut, .chParityOut, .chDataOe, .chReply, .chReject,
        .chEndOfRecord, .chDataIn, .chParityIn, .chRead, .chWrite, .chConnect, .chFunction, .chDataStrobe,
        .chMasterClear, .chRunning);
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_done;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xf(input int kind, input logic [11:0] w, input logic bad, input logic [3:0] exp);
        logic [3:0] ans;
        ioch_chan_model_inst.xfer(kind, w, bad, ans);
        chk("answer", {12'h000, ans}, {12'h000, exp});
        if (ans[3] && !exp[3]) test_done();
    endtask : xf
    task automatic t_connect;
        xf(0, CODE ^ 12'h001, 1'b0, 4'h8);
        xf(0, CODE, 1'b0, 4'h2);
        chk("connected", usrConnected, 16'h0000);
        usrConnectOk = 1'b1;
        xf(0, CODE, 1'b1, 4'h2);
        chk("parity error", chParityError, 16'h0001);
        xf(0, CODE, 1'b0, 4'h1);
        chk("connected", usrConnected, 16'h0001);
        chk("parity error", chParityError, 16'h0000);
    endtask : t_connect
    task automatic t_func;
        xf(1, 12'h015, 1'b0, 4'h2);
        usrFunctionOk = 1'b1;
        xf(1, 12'h022, 1'b0, 4'h1);
        chk("function code", usrFuncCode, 16'h0022);
    endtask : t_func
    task automatic t_write;
        logic [47:0] ws = 48'hA5C000FFF801;
        logic [11:0] w;
        for (int i = 0; i < 4; i++) begin
            w = ws[47 - 12 * i -: 12];
            xf(2, w, i == 2, 4'h1);
            chk("rx word", usrRxData, w);
            chk("parity error", chParityError, i == 2);
        end
    endtask : t_write
    task automatic t_read;
        usrTxValid = 1'b1;
        usrTxData = 12'h3B6;
        xf(3, 12'h000, 1'b0, 4'h1);
        chk("read word", ioch_chan_model_inst.seenWord, 16'h03B6);
        chk("read parity", ^{ioch_chan_model_inst.seenWord, ioch_chan_model_inst.seenPar}, 16'h0001);
        usrTxValid = 1'b0;
        usrTxEnd = 1'b1;
        xf(3, 12'h000, 1'b0, 4'h4);
        usrTxEnd = 1'b0;
    endtask : t_read
    task automatic t_side;
        usrStatus = 12'h5A3;
        usrIntCond = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("status", chStatus, 16'h05A3);
        chk("interrupt", chInterrupt, 16'h0001 << UNIT);
        ioch_chan_model_inst.setLevels(1'b0, 1'b0);
        repeat (5) @(posedge clk);
        #1;
        chk("interrupt", chInterrupt, 16'h0000);
        ioch_chan_model_inst.setLevels(1'b1, 1'b1);
        repeat (5) @(posedge clk);
        #1;
        chk("status", chStatus, 16'h0000);
        chk("connected", usrConnected, 16'h0000);
        chk("master clear", usrMasterClear, 16'h0001);
        ioch_chan_model_inst.setLevels(1'b0, 1'b1);
        repeat (5) @(posedge clk);
        #1;
        chk("master clear", usrMasterClear, 16'h0000);
        xf(1, 12'h022, 1'b0, 4'h8);
    endtask : t_side
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rstn, usrConnectOk, usrFunctionOk, usrIntCond, usrTxValid, usrTxEnd} = 6'h00;
        {usrStatus, usrTxData} = 24'h000000;
        n_mismatch = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("idle outputs", {chReply, chReject, chEndOfRecord, chDataOe}, 16'h0000);
        t_connect();
        t_func();
        t_write();
        t_read();
        t_side();
        test_done();
    end
endmodule : io_channel_handshake_bench
`default_nettype wire
